// ===== hw/mcms_regs.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mcms_regs
    import mcms_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        softReset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        txBusy,
    input  wire logic        rxBusy,
    input  wire logic        phyLinkUp,
    input  wire logic        phySpeedHundred,
    input  wire logic        phyFullDuplex,
    input  wire logic        phyReversed,
    input  wire logic        phyAutonegDone,
    output logic             txActive,
    output logic             rxActive,
    output logic             txResetPulse,
    output logic             rxResetPulse
);
    // ==========================================
    // bus phase tracking
    logic                 dpValid_r;
    logic                 dpWrite_r;
    logic [31:0]          dpAddr_r;
    logic                 addrTake;
    logic                 cmdWr;
    logic                 cfgRd;
    logic                 cmdRd;
    logic [31:0]          rdData_nxt;
    logic [31:0]          hrdata_r;
    logic                 hreadyout_r;
    logic                 hresp_r;
    logic [NCH-1:0]       enP_r;
    logic [NCH-1:0]       disP_r;
    logic [NCH-1:0]       rstP_r;
    logic [NCH-1:0]       act_r;
    logic [NCH-1:0]       chanBusy;
    logic [STAT_W-1:0]    phySync1_r;
    logic [STAT_W-1:0]    phySync2_r;
    logic [STAT_W-1:0]    stat_r;
    logic [STAT_W-1:0]    stat_nxt;
    mcms_chan_state_t     state_r [NCH];

    assign addrTake  = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign cmdWr     = dpValid_r && dpWrite_r && (dpAddr_r == CMD_OFS);
    assign cmdRd     = addrTake && !hwrite && (haddr == CMD_OFS);
    assign cfgRd     = addrTake && !hwrite && (haddr == CFG_OFS);
    assign chanBusy  = {rxBusy, txBusy};
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign hrdata    = hrdata_r;
    assign txActive  = act_r[0];
    assign rxActive  = act_r[1];
    assign txResetPulse = rstP_r[0];
    assign rxResetPulse = rstP_r[1];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dpValid_r <= 1'b0;
            dpWrite_r <= 1'b0;
            dpAddr_r  <= 32'h0000_0000;
        end else begin
            dpValid_r <= addrTake;
            dpWrite_r <= hwrite;
            dpAddr_r  <= haddr;
        end
    end

    // zero wait states, answer is always okay
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hreadyout_r <= 1'b0;
            hresp_r     <= HRESP_OKAY;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= HRESP_OKAY;
        end
    end

    // ==========================================
    // read data, sampled at the address phase
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        if (cmdRd) begin
            rdData_nxt[EN_POS[0]] = act_r[0];
            rdData_nxt[EN_POS[1]] = act_r[1];
        end else if (cfgRd) begin
            rdData_nxt[LINK_UP_POS:AUTONEG_POS] = stat_r;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hrdata_r <= 32'h0000_0000;
        end else begin
            hrdata_r <= rdData_nxt;
        end
    end

    // ==========================================
    // media status capture
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            phySync1_r <= '0;
            phySync2_r <= '0;
        end else begin
            phySync1_r <= {phyLinkUp, phySpeedHundred, phyFullDuplex,
                           phyReversed, phyAutonegDone};
            phySync2_r <= phySync1_r;
        end
    end

    always_comb begin
        stat_nxt    = phySync2_r;
        stat_nxt[1] = phySync2_r[1] & ~phySync2_r[3];
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stat_r <= CFG_RESET[LINK_UP_POS:AUTONEG_POS];
        end else if (softReset) begin
            stat_r <= CFG_RESET[LINK_UP_POS:AUTONEG_POS];
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ==========================================
    // per channel command pulses and state machine
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            mcms_chan_state_t stateNxt;

            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    enP_r[ch]  <= 1'b0;
                    disP_r[ch] <= 1'b0;
                    rstP_r[ch] <= 1'b0;
                end else begin
                    enP_r[ch]  <= cmdWr && hwdata[EN_POS[ch]]
                                  && !hwdata[DIS_POS[ch]];
                    disP_r[ch] <= cmdWr && hwdata[DIS_POS[ch]];
                    rstP_r[ch] <= (cmdWr && hwdata[RST_POS[ch]])
                                  || softReset;
                end
            end

            always_comb begin
                stateNxt = state_r[ch];
                if (rstP_r[ch]) begin
                    stateNxt = CH_IDLE;
                end else begin
                    case (state_r[ch])
                        CH_IDLE: begin
                            if (enP_r[ch]) begin
                                stateNxt = CH_RUN;
                            end
                        end
                        CH_RUN: begin
                            if (disP_r[ch]) begin
                                stateNxt = chanBusy[ch] ? CH_STOP
                                                        : CH_IDLE;
                            end
                        end
                        CH_STOP: begin
                            if (!chanBusy[ch]) begin
                                stateNxt = CH_IDLE;
                            end
                        end
                        default: begin
                            stateNxt = CH_IDLE;
                        end
                    endcase
                end
            end

            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    state_r[ch] <= CH_IDLE;
                    act_r[ch]   <= 1'b0;
                end else begin
                    state_r[ch] <= stateNxt;
                    act_r[ch]   <= (stateNxt != CH_IDLE);
                end
            end
        end
    endgenerate

    // ==========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    chk_rxrst_idle: assert property (
        rstP_r[1] |=> !rxActive && !rstP_r[1] || $past(softReset))
        else $error("receive reset left receiver active");

    chk_txrst_idle: assert property (
        cmdWr && hwdata[RST_POS[0]] |=> txResetPulse ##1 !txActive)
        else $error("transmit reset did not idle transmitter");

    chk_rxdis_drain: assert property (
        rxActive && disP_r[1] && !rstP_r[1] && rxBusy
        |=> rxActive)
        else $error("receiver stopped before packet end");

    chk_rxstop_hold: assert property (
        state_r[1] == CH_STOP && rxBusy && !rstP_r[1]
        |=> state_r[1] == CH_STOP)
        else $error("receiver left drain while busy");

    chk_rxdis_idle: assert property (
        rxActive && disP_r[1] && !rstP_r[1] && !rxBusy |=> !rxActive)
        else $error("receiver did not stop on disable");

    chk_rxdis_win: assert property (
        cmdWr && hwdata[DIS_POS[1]] && hwdata[EN_POS[1]] && !rxActive
        && !softReset |=> ##1 !rxActive)
        else $error("receive enable won over disable");

    chk_rxdis_en: assert property (
        cmdWr && hwdata[DIS_POS[1]] && hwdata[EN_POS[1]] |=> !enP_r[1])
        else $error("receive enable pulse despite disable");

    chk_rxen_start: assert property (
        cmdWr && hwdata[EN_POS[1]] && !hwdata[DIS_POS[1]]
        && !hwdata[RST_POS[1]] && !softReset && state_r[1] == CH_IDLE
        |=> ##1 rxActive)
        else $error("receive enable did not start receiver");

    chk_rx_readback: assert property (
        dpValid_r && !dpWrite_r && dpAddr_r == CMD_OFS
        |-> hrdata[EN_POS[1]] == $past(rxActive)
            && hrdata[DIS_POS[1]] == 1'b0 && hrdata[RST_POS[1]] == 1'b0)
        else $error("receive enable readback wrong");

    chk_txcmd_zero: assert property (
        dpValid_r && !dpWrite_r && dpAddr_r == CMD_OFS
        |-> hrdata[DIS_POS[0]] == 1'b0 && hrdata[RST_POS[0]] == 1'b0)
        else $error("transmit command bits read nonzero");

    chk_txdis_wait: assert property (
        txActive && disP_r[0] && !rstP_r[0] && !txBusy |=> !txActive)
        else $error("transmitter did not halt on disable");

    chk_txdis_drain: assert property (
        txActive && disP_r[0] && !rstP_r[0] && txBusy |=> txActive)
        else $error("transmitter stopped before packet end");

    chk_txstop_hold: assert property (
        state_r[0] == CH_STOP && txBusy && !rstP_r[0]
        |=> state_r[0] == CH_STOP)
        else $error("transmitter left drain while busy");

    chk_txdis_win: assert property (
        cmdWr && hwdata[DIS_POS[0]] && hwdata[EN_POS[0]] |=> !enP_r[0])
        else $error("transmit enable won over disable");

    chk_tx_readback: assert property (
        dpValid_r && !dpWrite_r && dpAddr_r == CMD_OFS
        |-> hrdata[EN_POS[0]] == $past(txActive))
        else $error("transmit enable readback wrong");

    chk_txen_start: assert property (
        cmdWr && hwdata[EN_POS[0]] && !hwdata[DIS_POS[0]]
        && !hwdata[RST_POS[0]] && !softReset && state_r[0] == CH_IDLE
        |=> ##1 txActive)
        else $error("transmit enable did not start transmitter");

    chk_media_read: assert property (
        dpValid_r && !dpWrite_r && dpAddr_r == CFG_OFS
        |-> hrdata[LINK_UP_POS:AUTONEG_POS] == $past(stat_r)
            && hrdata[26:0] == 27'h0000000)
        else $error("media status readback wrong");

    chk_status_link: assert property (
        !softReset |=> stat_r[4] == $past(phySync2_r[4]))
        else $error("link flag wrong");

    chk_status_path: assert property (
        !softReset |=> stat_r[3:2] == $past(phySync2_r[3:2])
                       && stat_r[0] == $past(phySync2_r[0]))
        else $error("speed duplex or autoneg flag wrong");

    chk_duplex_flag: assert property (
        !softReset |=> stat_r[2] == $past(phySync2_r[2]))
        else $error("full duplex flag wrong");

    chk_autoneg_flag: assert property (
        !softReset |=> stat_r[0] == $past(phySync2_r[0]))
        else $error("autonegotiation flag wrong");

    chk_pol_speed: assert property (
        stat_r[3] |-> !stat_r[1])
        else $error("reversed polarity shown at 100");

    chk_pol_pass: assert property (
        !softReset && !phySync2_r[3] |=> stat_r[1] == $past(phySync2_r[1]))
        else $error("reversed polarity flag lost at 10");

    chk_cfg_soft: assert property (
        softReset |=> stat_r == '0)
        else $error("media status not cleared by soft reset");

    chk_cmd_pulse: assert property (
        enP_r[0] || disP_r[0] |-> $past(cmdWr))
        else $error("command pulse without a write");

    chk_rxcmd_pulse: assert property (
        enP_r[1] || disP_r[1] |-> $past(cmdWr))
        else $error("receive command pulse without a write");

    chk_rxrst_pulse: assert property (
        cmdWr && hwdata[RST_POS[1]] |=> rxResetPulse ##1 !rxActive)
        else $error("receive reset did not idle receiver");

    chk_rxrst_src: assert property (
        rxResetPulse |-> $past(cmdWr) && $past(hwdata[RST_POS[1]]) || $past(softReset))
        else $error("receive reset pulse without a request");

    chk_txrst_src: assert property (
        txResetPulse |-> $past(cmdWr) && $past(hwdata[RST_POS[0]]) || $past(softReset))
        else $error("transmit reset pulse without a request");

    cov_tx_start: cover property (
        !txActive ##1 enP_r[0] ##1 txActive);
    cov_rx_drain: cover property (
        state_r[1] == CH_STOP ##1 state_r[1] == CH_IDLE);
    cov_tx_drain: cover property (
        state_r[0] == CH_STOP ##1 state_r[0] == CH_IDLE);
    cov_cfg_read: cover property (
        cfgRd ##1 hrdata[LINK_UP_POS]);
    cov_soft_rst: cover property (
        softReset && rxActive ##2 !rxActive);
endmodule : mcms_regs

// ===== hw/mcms_pkg.sv
// Behaviour
// - receive reset aborts, flushes, idles receiver
// - transmit reset aborts, flushes, idles transmitter
// - receive disable stops after current packet
// - receive disable beats receive enable
// - receive enable starts idle receiver
// - receive enable reads one while active
// - transmit disable halts after current packet
// - transmit disable beats transmit enable
// - transmit enable starts; reads one active
// - bit 31 shows phy link up
// - bit 30 shows 100 Mb/s speed
// - bit 29 shows full duplex
// - bit 28 reversed polarity at 10 only
// - media status register resets to zero
// - bit 27 shows autonegotiation complete
package mcms_pkg;
    // ==========================================
    // register map
    localparam logic [31:0] CMD_OFS   = 32'h0000_0000;
    localparam logic [31:0] CFG_OFS   = 32'h0000_0004;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    // ==========================================
    // command bits, index 0 transmit, 1 receive
    localparam int unsigned NCH         = 2;
    localparam int unsigned EN_POS  [2] = '{0, 2};
    localparam int unsigned DIS_POS [2] = '{1, 3};
    localparam int unsigned RST_POS [2] = '{4, 5};
    // ==========================================
    // media status bits
    localparam int unsigned LINK_UP_POS    = 31;
    localparam int unsigned SPEED_POS      = 30;
    localparam int unsigned DUPLEX_POS     = 29;
    localparam int unsigned REVERSED_POS   = 28;
    localparam int unsigned AUTONEG_POS    = 27;
    localparam int unsigned STAT_W         = 5;
    // ==========================================
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_RUN,
        CH_STOP
    } mcms_chan_state_t;
endpackage : mcms_pkg

// ===== verification/mac_command_and_media_status_bench.sv
`timescale 1ns/1ps
module mac_command_and_media_status_bench
    import mcms_pkg::*;
;
    // ==========================================
    // clock, reset and stimulus
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        softReset = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  busy = 2'h0;
    logic [4:0]  phy = 5'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rdQ;
    logic        respQ;
    logic        txActive;
    logic        rxActive;
    logic        txResetPulse;
    logic        rxResetPulse;
    int          pc [2] = '{0, 0};
    int          miscompares = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [31:0] rd;

    always #25 mclk = ~mclk;

    mcms_regs dut_u (.mclk(mclk), .reset(reset), .softReset(softReset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txBusy(busy[0]), .rxBusy(busy[1]), .phyLinkUp(phy[4]), .phySpeedHundred(phy[3]),
        .phyFullDuplex(phy[2]), .phyReversed(phy[1]), .phyAutonegDone(phy[0]),
        .txActive(txActive), .rxActive(rxActive), .txResetPulse(txResetPulse),
        .rxResetPulse(rxResetPulse));

    wire [1:0] act = {rxActive, txActive};

    // read data as it stood before each edge
    always @(posedge mclk) rdQ <= hrdata;
    always @(posedge mclk) respQ <= hresp;
    always @(negedge mclk) begin
        pc[0] += int'(txResetPulse === 1'b1);
        pc[1] += int'(rxResetPulse === 1'b1);
    end

    // ==========================================
    // checking and closing
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] expCfg(input logic [4:0] p);
        return {p[4], p[3], p[2], p[1] & ~p[3], p[0], 27'h0};
    endfunction : expCfg

    // ==========================================
    // bus transfer, waits on hready in both phases
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        #1 rd = rdQ;
    endtask : ahb

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic cmd(input logic [31:0] d);
        @(posedge mclk);
        ahb(1'b1, CMD_OFS, d);
        settle(2);
    endtask : cmd

    // ==========================================
    // tests
    initial begin
        void'($urandom(32'ha1b2));
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        settle(2);
        ahb(1'b0, CFG_OFS, 32'h0);
        chk(rd, CFG_RESET);
        ahb(1'b0, CMD_OFS, 32'h0);
        chk(rd, CMD_RESET);
        $display("test reset values done");
        for (int ch = 0; ch < 2; ch++) begin
            cmd(32'h1 << EN_POS[ch]);
            chk(act[ch], 1'b1);
            ahb(1'b0, CMD_OFS, 32'h0);
            chk(rd, 32'h1 << EN_POS[ch]);
            busy[ch] <= 1'b1;
            cmd(32'h1 << DIS_POS[ch]);
            chk(act[ch], 1'b1);
            busy[ch] <= 1'b0;
            settle(2);
            chk(act[ch], 1'b0);
            cmd((32'h1 << EN_POS[ch]) | (32'h1 << DIS_POS[ch]));
            chk(act[ch], 1'b0);
            cmd(32'h1 << EN_POS[ch]);
            cmd(32'h1 << DIS_POS[ch]);
            chk(act[ch], 1'b0);
            cmd(32'h1 << EN_POS[ch]);
            busy[ch] <= 1'b1;
            rd = 32'(pc[ch]);
            cmd(32'h1 << RST_POS[ch]);
            chk(act[ch], 1'b0);
            chk(32'(pc[ch]) - rd, 32'h1);
            busy[ch] <= 1'b0;
            ahb(1'b0, CMD_OFS, 32'h0);
            chk(rd, 32'h0);
            $display("test channel %0d done", ch);
        end
        for (int i = 0; i < 24; i++) begin
            phy <= 5'($urandom());
            busy <= 2'($urandom());
            settle(4);
            ahb(1'b0, CFG_OFS, 32'h0);
            chk(rd, expCfg(phy));
            ahb(1'b1, CFG_OFS, $urandom());
            ahb(1'b0, CFG_OFS, 32'h0);
            chk(rd, expCfg(phy));
        end
        $display("test media status done");
        busy <= 2'h0;
        ahb(1'b1, 32'h8, $urandom());
        ahb(1'b0, 32'h8, 32'h0);
        chk(rd, 32'h0);
        chk(32'(respQ), 32'(HRESP_OKAY));
        cmd(32'h5);
        rd = 32'(pc[0] + pc[1]);
        softReset <= 1'b1;
        @(posedge mclk);
        softReset <= 1'b0;
        settle(3);
        chk(32'(act), 32'h0);
        chk(32'(pc[0] + pc[1]) - rd, 32'h2);
        $display("test soft reset done");
        end_sim();
    end
endmodule : mac_command_and_media_status_bench
